// ---- rtl/wdt_pkg.sv ----
// Shared constants for the windowed watchdog control block
package wdt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] CONTROL_INDEX = 12'h0FD4;
    localparam logic [11:0] CODE_PORT_INDEX = 12'h0FD5;
    localparam logic [11:0] STATE_INDEX = 12'h0FD8;
    localparam logic [31:0] CONTROL_ADDR = {18'h0_0000, CONTROL_INDEX, 2'h0};
    localparam logic [31:0] CODE_PORT_ADDR = {18'h0_0000, CODE_PORT_INDEX, 2'h0};
    localparam logic [31:0] STATE_ADDR = {18'h0_0000, STATE_INDEX, 2'h0};

    // Control and state register field positions
    localparam int RUN_BIT = 0;
    localparam int ACTION_BIT = 1;
    localparam int PERIOD_LSB = 2;
    localparam int WINDOW_LSB = 4;
    localparam int FIXED_ZERO_BIT = 6;
    localparam int FIXED_ONE_BIT = 7;
    localparam int ACTIVE_BIT = 0;

    // Reset values
    localparam logic RUN_RESET = 1'h1;
    localparam logic ACTION_RESET = 1'h1;
    localparam logic [1:0] PERIOD_RESET = 2'h3;
    localparam logic [1:0] WINDOW_RESET = 2'h0;
    localparam logic [7:0] CODE_PORT_RESET = 8'h00;

    // Control codes
    localparam logic [7:0] CLEAR_CODE = 8'h4E;
    localparam logic [7:0] DISABLE_CODE = 8'hB1;

    // Clear-window encodings
    localparam logic [1:0] WINDOW_ANY = 2'h0;
    localparam logic [1:0] WINDOW_HALF = 2'h2;
    localparam logic [1:0] WINDOW_QUARTER = 2'h3;

    // Counter geometry and timing
    localparam int COUNT_W = 8;
    localparam int COUNT_LOG2 = 8;
    localparam int PRESCALE_W = 16;
    localparam int PERIOD_LOG2_MIN_DEFAULT = 18;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam real CLK_PERIOD_NS = 10.0;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage

// ---- rtl/wdt_code_if.sv ----
// Code-port write path between the bus side and the code decoder
`timescale 1ns/10ps
interface wdt_code_if;
    logic write_valid;
    logic [7:0] code;
    logic clear_strobe;
    logic disable_strobe;

    modport issuer (output write_valid, output code, input clear_strobe, input disable_strobe);
    modport decoder (input write_valid, input code, output clear_strobe, output disable_strobe);
endinterface

// ---- rtl/wdt_code_decoder.sv ----
// Decodes values written to the code port into clear and disable strobes
`timescale 1ns/10ps
module wdt_code_decoder (
    wdt_code_if.decoder port
);
    import wdt_pkg::*;

    // Every other value falls through with no strobe
    assign port.clear_strobe = port.write_valid && (port.code == CLEAR_CODE);
    assign port.disable_strobe = port.write_valid && (port.code == DISABLE_CODE);
endmodule

// ---- rtl/wdt_prescaler.sv ----
// Source clock divider producing the up-counter tick enable
`timescale 1ns/10ps
module wdt_prescaler #(
    parameter int PERIOD_LOG2_MIN = wdt_pkg::PERIOD_LOG2_MIN_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic enable,
    input wire logic restart,
    input wire logic [1:0] period_sel,
    // Tick out
    output logic tick
);
    import wdt_pkg::*;

    logic [PRESCALE_W-1:0] div;
    logic [4:0] shift_amt;
    logic [PRESCALE_W-1:0] mask;

    // 256 ticks make one overflow period, so each code adds two bits of division
    always_comb begin
        shift_amt = 5'(PERIOD_LOG2_MIN - COUNT_LOG2) + {2'h0, period_sel, 1'h0};
        mask = ~({PRESCALE_W{1'b1}} << shift_amt);
    end

    assign tick = enable && !restart && ((div & mask) == mask);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div <= '0;
        end else if (restart || !enable) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
endmodule

// ---- rtl/windowed_watchdog_control.sv ----
// Windowed watchdog control: settings, lock, clear window and code port
// Behaviour
// - Action select 0: counter overflow raises an interrupt request, not reset.
// - Period select 00/01/10/11 gives 2^18/2^20/2^22/2^24 clock periods per overflow.
// - Window 10: clear in first half raises interrupt; accepted only afterwards.
// - Window 11: clear in first three quarters raises interrupt; accepted afterwards.
// - While run is 1, writes leave window, period and action unchanged.
// - Write setting run from 0 to 1 also loads new settings.
// - Control reads return bit 7 as 1 and bit 6 as 0.
// - Writing the clear code clears the counter, subject to the window.
// - Disable code stops and zeroes the counter only while run is 0.
// - Any other code port value is ignored.
// - Action select 1: counter overflow raises a reset request.
// - After reset the run bit is 1 and the watchdog counts.
// - Window 00: clear code accepted at any time.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module windowed_watchdog_control #(
    parameter int PERIOD_LOG2_MIN = wdt_pkg::PERIOD_LOG2_MIN_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Watchdog events
    output logic irq_request,
    output logic reset_request,
    output logic running
);
    import wdt_pkg::*;

    wdt_code_if code_if ();

    logic dp_write;
    logic [11:0] dp_index;
    logic addr_valid;
    logic [31:0] next_rdata;
    logic ctrl_write;
    logic [7:0] wbyte;
    logic run;
    logic action;
    logic [1:0] period;
    logic [1:0] window;
    logic [7:0] ctrl_value;
    logic active;
    logic [COUNT_W-1:0] count;
    logic tick;
    logic in_window;
    logic clear_take;
    logic clear_early;
    logic disable_take;
    logic start;
    logic restart;
    logic overflow;

    // Bus slave: always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dp_write <= 1'b0;
            dp_index <= '0;
        end else if (hready) begin
            dp_write <= addr_valid && hwrite;
            dp_index <= haddr[13:2];
        end
    end

    always_comb begin
        ctrl_value = 8'h00;
        ctrl_value[FIXED_ONE_BIT] = 1'b1;
        ctrl_value[FIXED_ZERO_BIT] = 1'b0;
        ctrl_value[WINDOW_LSB +: 2] = window;
        ctrl_value[PERIOD_LSB +: 2] = period;
        ctrl_value[ACTION_BIT] = action;
        ctrl_value[RUN_BIT] = run;
        next_rdata = 32'h0000_0000;
        if (haddr == CONTROL_ADDR) begin
            next_rdata[7:0] = ctrl_value;
        end else if (haddr == STATE_ADDR) begin
            next_rdata[ACTIVE_BIT] = active;
        end
    end

    // Code port and unmapped addresses read as zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    assign wbyte = hwdata[7:0];
    assign ctrl_write = dp_write && (dp_index == CONTROL_INDEX);

    // Control register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run <= RUN_RESET;
            action <= ACTION_RESET;
            period <= PERIOD_RESET;
            window <= WINDOW_RESET;
        end else if (ctrl_write) begin
            run <= wbyte[RUN_BIT];
            // Settings follow the lock held before this write, so a 0-to-1 write loads them
            if (!run) begin
                action <= wbyte[ACTION_BIT];
                period <= wbyte[PERIOD_LSB +: 2];
                window <= wbyte[WINDOW_LSB +: 2];
            end
        end
    end

    // Code port is write-only and holds nothing
    assign code_if.write_valid = dp_write && (dp_index == CODE_PORT_INDEX);
    assign code_if.code = wbyte;

    wdt_code_decoder u_decoder (
        .port(code_if.decoder)
    );

    // Window code 01 is treated like 00
    always_comb begin
        case (window)
            WINDOW_HALF: in_window = count[7];
            WINDOW_QUARTER: in_window = (count[7:6] == 2'h3);
            default: in_window = 1'b1;
        endcase
    end

    assign disable_take = code_if.disable_strobe && !run;
    assign clear_take = code_if.clear_strobe && active && in_window && !disable_take;
    assign clear_early = code_if.clear_strobe && active && !in_window;
    assign start = ctrl_write && !run && wbyte[RUN_BIT] && !active;
    assign restart = clear_take || disable_take || start;
    // Disable takes precedence over a coincident overflow
    assign overflow = tick && (count == COUNT_MAX) && !disable_take && !clear_take;

    wdt_prescaler #(
        .PERIOD_LOG2_MIN(PERIOD_LOG2_MIN)
    ) u_prescaler (
        .clk(clk),
        .reset_n(reset_n),
        .enable(active),
        .restart(restart),
        .period_sel(period),
        .tick(tick)
    );

    // Up counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active <= RUN_RESET;
            count <= '0;
        end else if (disable_take) begin
            active <= 1'b0;
            count <= '0;
        end else begin
            if (start) begin
                active <= 1'b1;
            end
            if (clear_take) begin
                count <= '0;
            end else if (tick) begin
                count <= count + 1'b1;
            end
        end
    end

    // Requests are one-cycle pulses; a rejected clear leaves the count running
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_request <= 1'b0;
            reset_request <= 1'b0;
        end else begin
            irq_request <= (overflow && !action) || clear_early;
            reset_request <= overflow && action;
        end
    end

    assign running = active;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence clear_accepted_s;
        clear_take;
    endsequence

    sequence restart_from_zero_s;
        (count == 8'h00) ##1 (count == 8'h00) [*1];
    endsequence

    sequence early_clear_s(logic [1:0] code);
        code_if.clear_strobe && active && (window == code) && !disable_take;
    endsequence

    overflow_irq_a: assert property (
        overflow && !action |=> irq_request && !reset_request
    ) else $error("overflow with action 0 did not raise only an interrupt");

    overflow_rst_a: assert property (
        overflow && action |=> reset_request && !irq_request
    ) else $error("overflow with action 1 did not raise a reset request");

    count_on_tick_a: assert property (
        (count != $past(count)) && $past(!clear_take && !disable_take) |-> $past(tick)
    ) else $error("counter moved without a source tick");

    half_window_a: assert property (
        early_clear_s(WINDOW_HALF) and (count < 8'h80)
        |=> irq_request && ((count != 8'h00) || ($past(count) == 8'h00))
    ) else $error("early clear in half window not flagged or wrongly accepted");

    quarter_window_a: assert property (
        early_clear_s(WINDOW_QUARTER) and (count >= 8'h80) and (count < 8'hC0)
        |=> irq_request && (count >= 8'h80)
    ) else $error("early clear in quarter window not flagged or wrongly accepted");

    late_quarter_a: assert property (
        early_clear_s(WINDOW_QUARTER) and (count >= 8'hC0) |=> (count == 8'h00) && !irq_request
    ) else $error("clear after three quarters not accepted");

    settings_locked_a: assert property (
        run |=> $stable(window) && $stable(period) && $stable(action)
    ) else $error("settings changed while run was set");

    start_loads_a: assert property (
        ctrl_write && !run && wbyte[RUN_BIT]
        |=> run && (window == $past(wbyte[WINDOW_LSB +: 2]))
        && (period == $past(wbyte[PERIOD_LSB +: 2])) && (action == $past(wbyte[ACTION_BIT]))
    ) else $error("start write did not load settings");

    fixed_bits_a: assert property (
        addr_valid && !hwrite && (haddr == CONTROL_ADDR)
        |=> hrdata[FIXED_ONE_BIT] && !hrdata[FIXED_ZERO_BIT]
    ) else $error("control read fixed bits wrong");

    clear_restart_a: assert property (
        clear_accepted_s |=> restart_from_zero_s or (count == 8'h00) ##1 (count == 8'h01)
    ) else $error("accepted clear did not restart the counter from zero");

    disable_take_a: assert property (
        code_if.disable_strobe && !run |=> !active && (count == 8'h00) && !irq_request
        && !reset_request
    ) else $error("disable code with run 0 did not stop the watchdog");

    disable_ignored_a: assert property (
        code_if.disable_strobe && run && active |=> active
    ) else $error("disable code with run 1 stopped the watchdog");

    invalid_code_a: assert property (
        code_if.write_valid && (wbyte != CLEAR_CODE) && (wbyte != DISABLE_CODE)
        |-> !code_if.clear_strobe && !code_if.disable_strobe
    ) else $error("invalid code produced a strobe");

    reset_enabled_a: assert property (
        $rose(reset_n) |-> run && active && (count == 8'h00)
    ) else $error("watchdog not enabled after reset");

    open_window_a: assert property (
        early_clear_s(WINDOW_ANY) |=> (count == 8'h00) && !irq_request
    ) else $error("clear not accepted in open window");
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the windowed watchdog control block
`timescale 1ns/10ps
module tb;
    import wdt_pkg::*;
    // Shortened prescale so one overflow at period 00 takes 1024 clocks
    localparam int LOG2_MIN = 10;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq_request;
    logic reset_request;
    logic running;
    int failures = 0;
    int checks = 0;
    int irq_seen = 0;
    int rst_seen = 0;
    int m_ctrl;
    int m_active;
    logic [31:0] rd;

    assign hready = hreadyout;
    always #5 clk = ~clk;

    windowed_watchdog_control #(.PERIOD_LOG2_MIN(LOG2_MIN)) dut_u (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq_request(irq_request), .reset_request(reset_request), .running(running)
    );

    always @(posedge clk) begin
        if (irq_request === 1'b1) irq_seen <= irq_seen + 1;
        if (reset_request === 1'b1) rst_seen <= rst_seen + 1;
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; upper write bits are random junk
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [7:0] data);
        logic [23:0] junk;
        junk = 24'($urandom());
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {junk, data};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        check(hresp, HRESP_OKAY);
        hsel <= 1'b0;
    endtask

    task automatic write(input logic [31:0] addr, input int data);
        bus(1'b1, addr, data[7:0]);
        if (addr == CONTROL_ADDR) begin
            if (m_ctrl % 2 == 1) begin
                m_ctrl = (m_ctrl & 'h3E) | (data & 1);
            end else begin
                if (data % 2 == 1) m_active = 1;
                m_ctrl = data & 'h3F;
            end
        end else if (addr == CODE_PORT_ADDR && data == 'hB1 && m_ctrl % 2 == 0) begin
            m_active = 0;
        end
    endtask

    task automatic rd_check(input logic [31:0] addr);
        int exp;
        exp = 0;
        if (addr == CONTROL_ADDR) exp = 'h80 | m_ctrl;
        if (addr == STATE_ADDR) exp = m_active;
        bus(1'b0, addr, 8'h00);
        check(rd, 32'(exp));
    endtask

    // Waits for the next pulse and checks its kind and its distance from now
    task automatic wait_evt(input int want_irq, input int lo, input int hi);
        int i0;
        int r0;
        int n;
        i0 = irq_seen;
        r0 = rst_seen;
        n = 0;
        while (irq_seen == i0 && rst_seen == r0 && n < hi) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(irq_seen - i0), 32'(want_irq));
        check(32'(rst_seen - r0), 32'(1 - want_irq));
        check(32'(n >= lo), 32'h0000_0001);
    endtask

    task automatic restart(input int act, input int per, input int win);
        write(CONTROL_ADDR, m_ctrl & 'h3E);
        write(CODE_PORT_ADDR, 'hB1);
        write(CONTROL_ADDR, 1 | (act << 1) | (per << 2) | (win << 4));
        // The start lands at the data-phase edge; look once it has settled
        #1;
        check(running, 1'b1);
    endtask

    // Early clear raises an interrupt; a later clear restarts the full period
    task automatic win_test(input int win, input int d1, input int d2);
        restart(0, 0, win);
        repeat (d1) @(posedge clk);
        write(CODE_PORT_ADDR, 'h4E);
        wait_evt(1, 0, 4);
        repeat (d2) @(posedge clk);
        write(CODE_PORT_ADDR, 'h4E);
        wait_evt(1, 1016, 1032);
        $display("test window %0d done", win);
    endtask

    initial begin
        // About twice the longest expected run of roughly 28000 cycles
        repeat (60000) @(posedge clk);
        failures++;
        end_of_test();
    end

    initial begin
        int c;
        int t;
        c = $urandom(82296);
        m_ctrl = 'h0F;
        m_active = 1;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        check(running, 1'b1);
        rd_check(CONTROL_ADDR);
        rd_check(STATE_ADDR);
        rd_check(STATE_ADDR + 32'h0000_0004);
        $display("test reset done");
        write(CODE_PORT_ADDR, 'hB1);
        rd_check(STATE_ADDR);
        write(CONTROL_ADDR, 'h30);
        rd_check(CONTROL_ADDR);
        for (int i = 0; i < 6; i++) begin
            c = $urandom_range(255);
            if (c == 'h4E || c == 'hB1) c = 'h00;
            write(CODE_PORT_ADDR, c);
            rd_check(STATE_ADDR);
        end
        write(CODE_PORT_ADDR, 'hB1);
        rd_check(STATE_ADDR);
        check(running, 1'b0);
        $display("test lock and codes done");
        for (int p = 0; p < 3; p++) begin
            restart(0, p, 0);
            rd_check(CONTROL_ADDR);
            t = 1 << (2 + 2 * p);
            wait_evt(1, 255 * t - 4, 256 * t + 8);
        end
        $display("test periods done");
        restart(1, 0, 0);
        wait_evt(0, 1016, 1032);
        $display("test reset action done");
        restart(0, 0, 0);
        repeat (50) @(posedge clk);
        write(CODE_PORT_ADDR, 'h4E);
        wait_evt(1, 1016, 1032);
        $display("test open window done");
        win_test(2, 200, 400);
        win_test(3, 600, 250);
        end_of_test();
    end
endmodule
